/* design/sod_defines.svh */
// Summary of operation
// - Opcode 61 pulls all registers, 18 clocks.
// - Opcode 60 stores all registers, 17 clocks.
// - Opcode 9D pulls flags, 4 hit, 5 miss.
// - Prefix F0 holds bus lock next instruction.
// - 8F/000 pop: reg 3/4, memory 5/5 clocks.
// - FF/110 push: reg 2, memory 4, miss 4.
// - D0-D3,C0-C1 /011 rotate: 6 hit or register miss, 10 memory miss.
`ifndef SOD_DEFINES_SVH
`define SOD_DEFINES_SVH
// Opcode bytes
`define SOD_OP_PULL_ALL 8'h61
`define SOD_OP_STORE_ALL 8'h60
`define SOD_OP_STORE_FLAGS 8'h9C
`define SOD_OP_PULL_FLAGS 8'h9D
`define SOD_OP_LOCK 8'hF0
`define SOD_OP_POP_RM 8'h8F
`define SOD_OP_PUSH_RM 8'hFF
// Rotate group: upper six bits of D0/D1/D2/D3 and upper seven bits of C0/C1
`define SOD_OP_ROT_D 6'h34
`define SOD_OP_ROT_C 7'h60
// ModRM reg field values
`define SOD_REG_POP 3'h0
`define SOD_REG_PUSH 3'h6
`define SOD_REG_RCR 3'h3
// Mod value for register operand
`define SOD_MOD_REG 2'h3
// Clock counts
`define SOD_CLK_PULL_ALL 5'h12
`define SOD_CLK_STORE_ALL 5'h11
`define SOD_CLK_STORE_FLAGS 5'h02
`define SOD_CLK_PF_HIT 5'h04
`define SOD_CLK_PF_MISS 5'h05
`define SOD_CLK_POP_REG 5'h03
`define SOD_CLK_POP_REG_MISS 5'h04
`define SOD_CLK_POP_MEM 5'h05
`define SOD_CLK_PUSH_REG 5'h02
`define SOD_CLK_PUSH_MEM 5'h04
`define SOD_CLK_RCR_HIT 5'h06
`define SOD_CLK_RCR_MISS 5'h0A
`endif

/* design/sod_pkg.sv */
package sod_pkg;
	// Decoded instruction class
	typedef enum logic [7:0] {
		SOD_NONE = 8'h01,
		SOD_PULL_ALL = 8'h02,
		SOD_STORE_ALL = 8'h04,
		SOD_STORE_FLAGS = 8'h08,
		SOD_PULL_FLAGS = 8'h10,
		SOD_POP_RM = 8'h20,
		SOD_PUSH_RM = 8'h40,
		SOD_RCR = 8'h80
	} sod_class_t;
	// Sequencer states
	typedef enum logic [1:0] {
		SOD_IDLE = 2'h1,
		SOD_BUSY = 2'h2
	} sod_state_t;
endpackage

/* design/sod_cycle_counter.sv */
`timescale 1ns/1ps
`include "sod_defines.svh"
module sod_cycle_counter (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Load
	input wire logic load_in,
	input wire logic [4:0] count_in,
	// Status
	output logic last_out
);
	// Remaining clocks
	logic [4:0] remain;
	wire logic [4:0] next_remain = load_in ? count_in : (remain != 5'h00 ? remain - 5'h01 : 5'h00);
	// Countdown register
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			remain <= 5'h00;
		end else begin
			remain <= next_remain;
		end
	end
	// Final clock of the instruction
	assign last_out = (remain == 5'h01);
endmodule

/* design/sod_decode.sv */
`timescale 1ns/1ps
`include "sod_defines.svh"
module sod_decode (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Instruction bytes
	input wire logic issue_in,
	input wire logic [7:0] opcode_in,
	input wire logic [7:0] modrm_in,
	input wire logic protected_in,
	input wire logic cache_miss_in,
	// Memory access of the running instruction
	input wire logic mem_access_in,
	// Handshake
	output logic ready_out,
	output logic done_out,
	// Decode results
	output sod_pkg::sod_class_t class_out,
	output logic [4:0] clocks_out,
	output logic lock_out
);
	import sod_pkg::*;
	// Field split of the ModRM byte
	wire logic [1:0] mod_f = modrm_in[7:6];
	wire logic [2:0] reg_f = modrm_in[5:3];
	wire logic is_reg = (mod_f == `SOD_MOD_REG);
	// Rotate miss only counts with a memory operand; table counts same in both modes
	wire logic miss = cache_miss_in;
	wire logic mem_miss = miss & ~is_reg;
	// Opcode matches
	wire logic m_pa = (opcode_in == `SOD_OP_PULL_ALL);
	wire logic m_sa = (opcode_in == `SOD_OP_STORE_ALL);
	wire logic m_sf = (opcode_in == `SOD_OP_STORE_FLAGS);
	wire logic m_pf = (opcode_in == `SOD_OP_PULL_FLAGS);
	wire logic m_lk = (opcode_in == `SOD_OP_LOCK);
	wire logic m_pop = (opcode_in == `SOD_OP_POP_RM) && (reg_f == `SOD_REG_POP);
	wire logic m_push = (opcode_in == `SOD_OP_PUSH_RM) && (reg_f == `SOD_REG_PUSH);
	wire logic m_rcr = ((opcode_in[7:2] == `SOD_OP_ROT_D) || (opcode_in[7:1] == `SOD_OP_ROT_C))
		&& (reg_f == `SOD_REG_RCR);
	// Class selection
	wire sod_class_t dec_class = m_pa ? SOD_PULL_ALL :
		m_sa ? SOD_STORE_ALL :
		m_sf ? SOD_STORE_FLAGS :
		m_pf ? SOD_PULL_FLAGS :
		m_pop ? SOD_POP_RM :
		m_push ? SOD_PUSH_RM :
		m_rcr ? SOD_RCR : SOD_NONE;
	// Clock count selection
	wire logic [4:0] c_pf = miss ? `SOD_CLK_PF_MISS : `SOD_CLK_PF_HIT;
	wire logic [4:0] c_pop = is_reg ? (miss ? `SOD_CLK_POP_REG_MISS : `SOD_CLK_POP_REG)
		: `SOD_CLK_POP_MEM;
	wire logic [4:0] c_push = (is_reg && !miss) ? `SOD_CLK_PUSH_REG : `SOD_CLK_PUSH_MEM;
	wire logic [4:0] c_rcr = mem_miss ? `SOD_CLK_RCR_MISS : `SOD_CLK_RCR_HIT;
	wire logic [4:0] dec_clocks = m_pa ? `SOD_CLK_PULL_ALL :
		m_sa ? `SOD_CLK_STORE_ALL :
		m_sf ? `SOD_CLK_STORE_FLAGS :
		m_pf ? c_pf :
		m_pop ? c_pop :
		m_push ? c_push :
		m_rcr ? c_rcr : 5'h01;
	// Sequencer
	sod_state_t state;
	logic lock_armed;
	wire logic last;
	wire logic take = issue_in && (state == SOD_IDLE);
	wire logic take_instr = take && !m_lk;
	// Prefix is absorbed in one clock and arms the lock
	wire sod_state_t next_state = take_instr ? SOD_BUSY : ((state == SOD_BUSY && last) ? SOD_IDLE : state);
	assign ready_out = (state == SOD_IDLE);
	assign done_out = (state == SOD_BUSY) && last;
	sod_cycle_counter u_cnt (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.load_in(take_instr),
		.count_in(dec_clocks),
		.last_out(last)
	);
	// State and result registers
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= SOD_IDLE;
			class_out <= SOD_NONE;
			clocks_out <= 5'h00;
		end else begin
			state <= next_state;
			if (take_instr) begin
				class_out <= dec_class;
				clocks_out <= dec_clocks;
			end
		end
	end
	// Bus lock: armed by prefix, held during the next instruction's memory access
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			lock_armed <= 1'b0;
			lock_out <= 1'b0;
		end else begin
			if (take && m_lk) begin
				lock_armed <= 1'b1;
			end else if (done_out) begin
				lock_armed <= 1'b0;
			end
			lock_out <= lock_armed && (take_instr || (state == SOD_BUSY && !done_out)) && mem_access_in;
		end
	end
	// Miss flag of the previous clock, for the flag-pull check
	logic miss_q;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			miss_q <= 1'b0;
		end else begin
			miss_q <= miss;
		end
	end
	// Checks
	pull_all_count_a: assert property (@(posedge clk_in) disable iff (rst_in)
		take_instr && m_pa |=> clocks_out == 5'h12) else $error("pull all count wrong");
	store_all_count_a: assert property (@(posedge clk_in) disable iff (rst_in)
		take_instr && m_sa |=> clocks_out == 5'h11) else $error("store all count wrong");
	store_flags_done_a: assert property (@(posedge clk_in) disable iff (rst_in)
		take_instr && m_sf |=> !done_out ##1 done_out) else $error("store flags timing wrong");
	pull_flags_cnt_a: assert property (@(posedge clk_in) disable iff (rst_in)
		take_instr && m_pf |=> clocks_out == (miss_q ? 5'h05 : 5'h04)) else $error("pull flags count");
	lock_prefix_a: assert property (@(posedge clk_in) disable iff (rst_in)
		take && m_lk |=> lock_armed && ready_out) else $error("lock not armed");
	pop_reg_cnt_a: assert property (@(posedge clk_in) disable iff (rst_in)
		take_instr && m_pop && is_reg && !miss |=> clocks_out == 5'h03) else $error("pop count");
	push_mem_cnt_a: assert property (@(posedge clk_in) disable iff (rst_in)
		take_instr && m_push && !is_reg |=> clocks_out == 5'h04) else $error("push count");
	rcr_miss_cnt_a: assert property (@(posedge clk_in) disable iff (rst_in)
		take_instr && m_rcr && mem_miss |=> clocks_out == 5'h0A) else $error("rotate count");
endmodule

/* tb/sod_decode_tb_top.sv */
`timescale 1ns/1ps
module sod_decode_tb_top;
	import sod_pkg::*;
	logic clk_in, rst_in, issue_in, protected_in, cache_miss_in, mem_access_in;
	logic [7:0] opcode_in, modrm_in;
	logic ready_out, done_out, lock_out;
	sod_class_t class_out;
	logic [4:0] clocks_out;
	int n_mismatch, n_checks;
	sod_decode sod_decode_inst (.clk_in(clk_in), .rst_in(rst_in), .issue_in(issue_in), .opcode_in(opcode_in),
		.modrm_in(modrm_in), .protected_in(protected_in), .cache_miss_in(cache_miss_in),
		.mem_access_in(mem_access_in), .ready_out(ready_out), .done_out(done_out), .class_out(class_out),
		.clocks_out(clocks_out), .lock_out(lock_out));
	// Free running 25 ns clock
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	// Count a comparison, report a miss
	task automatic chk(input logic ok, input string msg);
		n_checks++;
		if (!ok) begin
			n_mismatch++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	// Issue one instruction, check class, count and when done arrives
	task automatic run(input logic [7:0] op, md, input logic miss, input sod_class_t cls, input int n);
		int k;
		@(posedge clk_in);
		issue_in <= 1'b1;
		opcode_in <= op;
		modrm_in <= md;
		cache_miss_in <= miss;
		@(posedge clk_in);
		issue_in <= 1'b0;
		#1;
		k = 1;
		chk(class_out === cls && clocks_out === n[4:0], "class or count");
		while (done_out !== 1'b1 && k < 40) begin
			@(posedge clk_in);
			#1;
			k++;
		end
		chk(k == n, "done timing");
	endtask
	// Whole register file moves, back to back
	task automatic t_all();
		run(8'h61, 8'h00, 1'b0, SOD_PULL_ALL, 18);
		run(8'h61, 8'h00, 1'b1, SOD_PULL_ALL, 18);
		run(8'h60, 8'h00, 1'b1, SOD_STORE_ALL, 17);
		run(8'h60, 8'h00, 1'b0, SOD_STORE_ALL, 17);
		$display("test all done");
	endtask
	// Flags store and pull, hit and miss
	task automatic t_flags();
		run(8'h9C, 8'h00, 1'b0, SOD_STORE_FLAGS, 2);
		run(8'h9C, 8'h00, 1'b1, SOD_STORE_FLAGS, 2);
		run(8'h9D, 8'h00, 1'b0, SOD_PULL_FLAGS, 4);
		run(8'h9D, 8'h00, 1'b1, SOD_PULL_FLAGS, 5);
		$display("test flags done");
	endtask
	// Pop and push of register and memory operands
	task automatic t_rm();
		run(8'h8F, 8'hC0, 1'b0, SOD_POP_RM, 3);
		run(8'h8F, 8'hC0, 1'b1, SOD_POP_RM, 4);
		run(8'h8F, 8'h06, 1'b0, SOD_POP_RM, 5);
		run(8'h8F, 8'h06, 1'b1, SOD_POP_RM, 5);
		run(8'hFF, 8'hF0, 1'b0, SOD_PUSH_RM, 2);
		run(8'hFF, 8'h30, 1'b0, SOD_PUSH_RM, 4);
		run(8'hFF, 8'h30, 1'b1, SOD_PUSH_RM, 4);
		$display("test rm done");
	endtask
	// Every rotate form, protected mode, hit and miss
	task automatic t_rcr();
		logic [7:0] ops [6] = '{8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hC0, 8'hC1};
		protected_in <= 1'b1;
		foreach (ops[i]) begin
			run(ops[i], 8'h18, 1'b0, SOD_RCR, 6);
			run(ops[i], 8'h18, 1'b1, SOD_RCR, 10);
		end
		run(8'hD1, 8'hD8, 1'b0, SOD_RCR, 6);
		$display("test rcr done");
	endtask
	// Lock prefix then a long instruction with memory traffic
	task automatic t_lock();
		@(posedge clk_in);
		issue_in <= 1'b1;
		opcode_in <= 8'hF0;
		@(posedge clk_in);
		opcode_in <= 8'h60;
		mem_access_in <= 1'b1;
		#1;
		chk(ready_out === 1'b1, "ready after prefix");
		@(posedge clk_in);
		issue_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		#1;
		chk(lock_out === 1'b1, "lock not held");
		repeat (20) @(posedge clk_in);
		mem_access_in <= 1'b0;
		#1;
		chk(lock_out === 1'b0 && ready_out === 1'b1, "lock not released");
		$display("test lock done");
	endtask
	// Verdict and end of run
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Watchdog against a hang
	initial begin
		repeat (5000) @(posedge clk_in);
		n_mismatch++;
		results();
	end
	// Main sequence
	initial begin
		rst_in = 1'b1;
		issue_in = 1'b0;
		opcode_in = 8'h00;
		modrm_in = 8'h00;
		protected_in = 1'b0;
		cache_miss_in = 1'b0;
		mem_access_in = 1'b0;
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		t_all();
		t_flags();
		t_rm();
		t_rcr();
		t_lock();
		results();
	end
endmodule
